// *** verilog/input_mapper_defs.vh ***
// Purpose: constants for the configurable input function mapper
// Assumes: AXI4-Lite byte addresses, 32-bit data words
// Notes: definitions only
`ifndef INPUT_MAPPER_DEFS_VH
`define INPUT_MAPPER_DEFS_VH

// ----------------------------------------
// sizes
// ----------------------------------------
`define NUM_INPUTS 14
`define NUM_BASE 8
`define NUM_EXP 6
`define ADDR_W 8

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_FUNC_BASE 8'h00
`define ADDR_FUNC_LAST 8'h34
`define ADDR_VSTATE 8'h40
`define ADDR_INSTAT 8'h44
`define ADDR_PIDEN 8'h48
`define ADDR_CTRL 8'h4c
`define ADDR_STATUS 8'h50

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define FUNC_RST 16'h0000
`define VSTATE_RST 16'hff00
`define VSTATE_LSB 8
`define PIDEN_RST 16'h0000
`define CTRL_POP_BIT 0
`define STAT_REFUSED_BIT 0
`define STAT_RUN_BIT 1
`define STAT_PLC_OFF_BIT 2
`define STAT_IDX_LSB 4

// ----------------------------------------
// function codes
// ----------------------------------------
`define CODE_NONE 16'h0000
`define CODE_MAX 16'h0032
`define CODE_MS1 16'h0001
`define CODE_MS2 16'h0002
`define CODE_MS3 16'h0003
`define CODE_MS4 16'h0004
`define CODE_PLC_OFF_A 16'h0024
`define CODE_PLC_OFF_B 16'h0025

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

// *** verilog/level_sync.v ***
// Purpose: two-flop synchroniser for a group of input levels
// Assumes: single clock, synchronous active-high reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module level_sync #(
  parameter W = 14
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // levels
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r;

  always @(posedge clk) begin
    if (srst) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// *** verilog/func_decode.v ***
// Purpose: gathers asserted drive-owned inputs by function code
// Assumes: codes packed 16 bits per terminal, terminal 0 lowest
// Notes: purely combinational
`timescale 1ns/1ps
`include "input_mapper_defs.vh"
module func_decode (
  // terminal codes and states
  input wire [16*`NUM_INPUTS-1:0] codes,
  input wire [`NUM_INPUTS-1:0] active,
  // decoded functions
  output reg [3:0] ms_bits,
  output reg plc_off
);
  integer i;
  reg [15:0] c;

  function is_code;
    input [15:0] have;
    input [15:0] want;
    begin
      is_code = (have == want);
    end
  endfunction

  always @* begin
    c = 16'h0000;
    ms_bits = 4'h0;
    plc_off = 1'b0;
    for (i = 0; i < `NUM_INPUTS; i = i + 1) begin
      c = codes[16*i +: 16];
      if (active[i]) begin
        if (is_code(c, `CODE_MS1)) ms_bits[0] = 1'b1;
        if (is_code(c, `CODE_MS2)) ms_bits[1] = 1'b1;
        if (is_code(c, `CODE_MS3)) ms_bits[2] = 1'b1;
        if (is_code(c, `CODE_MS4)) ms_bits[3] = 1'b1;
        if (is_code(c, `CODE_PLC_OFF_A) || is_code(c, `CODE_PLC_OFF_B))
          plc_off = 1'b1;
      end
    end
  end
endmodule

// *** verilog/input_mapper.v ***
// Purpose: maps fourteen configurable inputs to drive functions
// Assumes: AXI4-Lite register access, inputs synchronous-safe after sync
// Notes: speed and setpoint selection outputs are registered
`timescale 1ns/1ps
`include "input_mapper_defs.vh"
module input_mapper (
  // clock and reset
  input wire clk,
  input wire srst,
  // axi4-lite write address
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // terminals and card
  input wire [`NUM_INPUTS-1:0] term_in,
  input wire [`NUM_EXP-1:0] card_fitted,
  // drive and plc state
  input wire drive_running,
  input wire plc_run_or_stop,
  input wire [`NUM_INPUTS-1:0] plc_uses_input,
  // selections
  output reg [3:0] speed_index_r,
  output reg use_master_speed_r,
  output reg [2:0] setpoint_index_r,
  output reg use_setpoint_source_r,
  output reg pid_multi_active_r,
  output reg plc_disable_r,
  output reg [`NUM_INPUTS-1:0] plc_owned_r
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [15:0] func_r [0:`NUM_INPUTS-1];
  reg [15:0] vstate_r;
  reg [15:0] piden_r;
  reg setp_pop_r;
  reg refused_r;
  reg [`ADDR_W-1:0] awaddr_r;
  reg aw_held_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_held_r;

  wire [`NUM_INPUTS-1:0] term_sync;
  reg [`NUM_INPUTS-1:0] level;
  reg [`NUM_INPUTS-1:0] active;
  wire [16*`NUM_INPUTS-1:0] codes_flat;
  wire [3:0] ms_bits;
  wire plc_off;

  integer k_lvl;
  integer k_act;
  integer k_dup;
  integer k_rst;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16 = old;
      if (strb[0]) merge16[7:0] = data[7:0];
      if (strb[1]) merge16[15:8] = data[15:8];
    end
  endfunction

  function is_func_addr;
    input [`ADDR_W-1:0] a;
    begin
      is_func_addr = (a[1:0] == 2'h0) && (a <= `ADDR_FUNC_LAST);
    end
  endfunction

  function [3:0] func_index;
    input [`ADDR_W-1:0] a;
    begin
      func_index = a[5:2];
    end
  endfunction

  // ----------------------------------------
  // input levels
  // ----------------------------------------
  level_sync #(
    .W(`NUM_INPUTS)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d(term_in),
    .q(term_sync)
  );

  always @* begin
    level = term_sync;
    for (k_lvl = `NUM_BASE; k_lvl < `NUM_INPUTS; k_lvl = k_lvl + 1) begin
      if (!card_fitted[k_lvl - `NUM_BASE])
        level[k_lvl] = ~vstate_r[`VSTATE_LSB + k_lvl - `NUM_BASE];
    end
  end

  always @* begin
    for (k_act = 0; k_act < `NUM_INPUTS; k_act = k_act + 1) begin
      active[k_act] = level[k_act] && (func_r[k_act] != `CODE_NONE)
        && !plc_owned_r[k_act];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_INPUTS; g = g + 1) begin : pack
      assign codes_flat[16*g +: 16] = func_r[g];
    end
  endgenerate

  func_decode u_dec (
    .codes(codes_flat),
    .active(active),
    .ms_bits(ms_bits),
    .plc_off(plc_off)
  );

  // ----------------------------------------
  // ownership and selection
  // ----------------------------------------
  wire pid_mode = (piden_r != 16'h0000) && setp_pop_r;

  always @(posedge clk) begin
    if (srst) begin
      plc_disable_r <= 1'b0;
      plc_owned_r <= {`NUM_INPUTS{1'b0}};
      speed_index_r <= 4'h0;
      use_master_speed_r <= 1'b1;
      setpoint_index_r <= 3'h0;
      use_setpoint_source_r <= 1'b1;
      pid_multi_active_r <= 1'b0;
    end else begin
      plc_disable_r <= plc_off;
      if (plc_run_or_stop && !plc_off)
        plc_owned_r <= plc_uses_input;
      else
        plc_owned_r <= {`NUM_INPUTS{1'b0}};
      pid_multi_active_r <= pid_mode;
      if (pid_mode) begin
        speed_index_r <= {ms_bits[3], 3'h0};
        use_master_speed_r <= !ms_bits[3];
        setpoint_index_r <= ms_bits[2:0];
        use_setpoint_source_r <= (ms_bits[2:0] == 3'h0);
      end else begin
        speed_index_r <= ms_bits;
        use_master_speed_r <= (ms_bits == 4'h0);
        setpoint_index_r <= 3'h0;
        use_setpoint_source_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // write checks
  // ----------------------------------------
  reg dup_hit;
  reg [15:0] new_code;
  reg [3:0] widx;

  always @* begin
    widx = func_index(awaddr_r);
    new_code = 16'h0000;
    dup_hit = 1'b0;
    for (k_dup = 0; k_dup < `NUM_INPUTS; k_dup = k_dup + 1) begin
      if (widx == k_dup[3:0])
        new_code = merge16(func_r[k_dup], wdata_r, wstrb_r);
    end
    for (k_dup = 0; k_dup < `NUM_INPUTS; k_dup = k_dup + 1) begin
      if ((widx != k_dup[3:0]) && (new_code != `CODE_NONE) && (func_r[k_dup] == new_code))
        dup_hit = 1'b1;
    end
  end

  wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  wire wr_func = is_func_addr(awaddr_r);
  wire func_ok = (new_code <= `CODE_MAX)
    && !dup_hit
    && !drive_running;
  wire wr_mapped = wr_func || (awaddr_r == `ADDR_VSTATE) || (awaddr_r == `ADDR_PIDEN)
    || (awaddr_r == `ADDR_CTRL) || (awaddr_r == `ADDR_STATUS) || (awaddr_r == `ADDR_INSTAT);

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= {`ADDR_W{1'b0}};
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      vstate_r <= `VSTATE_RST;
      piden_r <= `PIDEN_RST;
      setp_pop_r <= 1'b0;
      refused_r <= 1'b0;
      for (k_rst = 0; k_rst < `NUM_INPUTS; k_rst = k_rst + 1) begin
        func_r[k_rst] <= `FUNC_RST;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        if (!wr_mapped) begin
          s_axi_bresp <= `RESP_DECERR;
        end else if (wr_func) begin
          if (func_ok) begin
            func_r[widx] <= new_code;
          end else begin
            s_axi_bresp <= `RESP_SLVERR;
            refused_r <= 1'b1;
          end
        end else if (awaddr_r == `ADDR_VSTATE) begin
          vstate_r <= merge16(vstate_r, wdata_r, wstrb_r);
        end else if (awaddr_r == `ADDR_PIDEN) begin
          piden_r <= merge16(piden_r, wdata_r, wstrb_r);
        end else if (awaddr_r == `ADDR_CTRL) begin
          if (wstrb_r[0]) setp_pop_r <= wdata_r[`CTRL_POP_BIT];
        end else if (awaddr_r == `ADDR_STATUS) begin
          if (wstrb_r[0] && wdata_r[`STAT_REFUSED_BIT]) refused_r <= 1'b0;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  reg [31:0] rd_word;
  reg [1:0] rd_resp;

  always @* begin
    rd_word = 32'h00000000;
    rd_resp = `RESP_OKAY;
    if (is_func_addr(s_axi_araddr)) begin
      rd_word[15:0] = func_r[func_index(s_axi_araddr)];
    end else begin
      case (s_axi_araddr)
        `ADDR_VSTATE: rd_word[15:0] = vstate_r;
        `ADDR_INSTAT: rd_word[`NUM_INPUTS-1:0] = level;
        `ADDR_PIDEN: rd_word[15:0] = piden_r;
        `ADDR_CTRL: rd_word[`CTRL_POP_BIT] = setp_pop_r;
        `ADDR_STATUS: begin
          rd_word[`STAT_REFUSED_BIT] = refused_r;
          rd_word[`STAT_RUN_BIT] = drive_running;
          rd_word[`STAT_PLC_OFF_BIT] = plc_disable_r;
          rd_word[`STAT_IDX_LSB +: 4] = speed_index_r;
        end
        default: rd_resp = `RESP_DECERR;
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_resp;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// *** bench/input_mapper_assertions.sv ***
// Purpose: port checks for input_mapper
// Assumes: top ports only, one clock
// Notes: bound below
`timescale 1ns/1ps
`include "input_mapper_defs.vh"
module input_mapper_checker (
  // clock and reset
  input wire clk,
  input wire srst,
  // bus
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // state and selections
  input wire drive_running,
  input wire plc_run_or_stop,
  input wire [3:0] speed_index_r,
  input wire use_master_speed_r,
  input wire [2:0] setpoint_index_r,
  input wire use_setpoint_source_r,
  input wire pid_multi_active_r,
  input wire plc_disable_r,
  input wire [`NUM_INPUTS-1:0] plc_owned_r
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  wire fw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr <= `ADDR_FUNC_LAST;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  code_range_a: assert property (fw && s_axi_wdata[15:0] > `CODE_MAX
    |-> ##2 s_axi_bvalid && s_axi_bresp == `RESP_SLVERR) else $error("code over range taken");
  run_lock_a: assert property (fw && drive_running
    |-> ##2 s_axi_bvalid && s_axi_bresp == `RESP_SLVERR) else $error("write while running taken");
  master_sel_a: assert property (use_master_speed_r == (speed_index_r == 4'h0))
    else $error("master speed select wrong");
  sp_source_a: assert property (use_setpoint_source_r == (setpoint_index_r == 3'h0))
    else $error("setpoint source select wrong");
  pid_index_a: assert property (pid_multi_active_r |-> speed_index_r[2:0] == 3'h0)
    else $error("speed bits used in pid mode");
  plc_release_a: assert property (plc_disable_r && $past(plc_disable_r)
    |-> plc_owned_r == 14'h0) else $error("plc kept inputs");
  plc_idle_a: assert property (!plc_run_or_stop [*4] |=> plc_owned_r == 14'h0)
    else $error("idle plc owns inputs");
  read_ans_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
endmodule
bind input_mapper input_mapper_checker i_chk (
  .clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .drive_running(drive_running), .plc_run_or_stop(plc_run_or_stop),
  .speed_index_r(speed_index_r), .use_master_speed_r(use_master_speed_r),
  .setpoint_index_r(setpoint_index_r), .use_setpoint_source_r(use_setpoint_source_r),
  .pid_multi_active_r(pid_multi_active_r), .plc_disable_r(plc_disable_r),
  .plc_owned_r(plc_owned_r));

// *** bench/contact_plc_model.sv ***
// Purpose: contacts and plc program model
// Assumes: bench sets the requests
// Notes: plc claims inputs only in run or stop
`timescale 1ns/1ps
module contact_plc_model (
  // clock
  input wire clk,
  // bench requests
  input wire [13:0] close_req,
  input wire plc_req,
  input wire [13:0] claim_req,
  // terminal side
  output logic [13:0] term_in = 14'h0,
  output logic plc_run_or_stop = 1'b0,
  output logic [13:0] plc_uses_input = 14'h0
);
  // ----------------------------------------
  // contacts and plc
  // ----------------------------------------
  always @(posedge clk) begin
    term_in <= close_req;
    plc_run_or_stop <= plc_req;
    plc_uses_input <= plc_req ? claim_req : 14'h0;
  end
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench for input_mapper
// Assumes: 25 MHz clock, bus answers checked from queues
// Notes: register bus and plc model drive the block
`timescale 1ns/1ps
`include "input_mapper_defs.vh"
module tb;
  logic clk = 0, srst = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, run = 0, plc_on = 0;
  logic [7:0] aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, r, vs;
  logic [13:0] close = 0, claim = 0;
  logic [5:0] card = 6'h3f;
  wire aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_d;
  wire [13:0] term, uses;
  wire plc_st;
  wire [3:0] spd;
  wire [2:0] setp;
  wire mst, src, pidm, ploff;
  wire [13:0] own;
  logic o_req = 0;
  logic [24:0] eo[$];
  logic [1:0] eb[$];
  logic [33:0] er[$];
  int errors = 0, samples_checked = 0, i, k;
  always #20 clk = ~clk;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  input_mapper i_dut (.clk(clk), .srst(srst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .term_in(term),
    .card_fitted(card), .drive_running(run), .plc_run_or_stop(plc_st), .plc_uses_input(uses),
    .speed_index_r(spd), .use_master_speed_r(mst), .setpoint_index_r(setp),
    .use_setpoint_source_r(src), .pid_multi_active_r(pidm), .plc_disable_r(ploff),
    .plc_owned_r(own));
  contact_plc_model i_far (.clk(clk), .close_req(close), .plc_req(plc_on), .claim_req(claim),
    .term_in(term), .plc_run_or_stop(plc_st), .plc_uses_input(uses));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp_b(input [1:0] e, input [1:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_r(input [33:0] e, input [33:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_o(input [24:0] e, input [24:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk(input [24:0] e);
    eo.push_back(e);
    @(posedge clk);
    o_req <= 1;
    @(posedge clk);
    o_req <= 0;
  endtask
  task automatic wr(input [7:0] a, input [15:0] d, input [1:0] e);
    int n = 0;
    eb.push_back(e);
    @(posedge clk);
    aw_a <= a; w_d <= {16'h0, d}; aw_v <= 1; w_v <= 1; b_r <= 1;
    do begin
      @(posedge clk);
      if (aw_rdy) aw_v <= 0;
      if (w_rdy) w_v <= 0;
    end while (!b_v && ++n < 40);
    b_r <= 0;
    if (n >= 40) begin errors++; finish_test(); end
  endtask
  task automatic rd(input [7:0] a, input [33:0] e);
    int n = 0;
    er.push_back(e);
    @(posedge clk);
    ar_a <= a; ar_v <= 1; r_r <= 1;
    do begin
      @(posedge clk);
      if (ar_rdy) ar_v <= 0;
    end while (!r_v && ++n < 40);
    r_r <= 0;
    if (n >= 40) begin errors++; finish_test(); end
  endtask
  function automatic [33:0] st(input rf, input rn, input pl, input [3:0] ix);
    return {26'h0, ix, 1'b0, pl, rn, rf};
  endfunction
  always @(posedge clk) begin
    if (b_v && b_r) cmp_b(eb.pop_front(), b_resp);
    if (r_v && r_r) cmp_r(er.pop_front(), {r_resp, r_d});
    if (o_req) cmp_o(eo.pop_front(), {mst, spd, src, setp, pidm, ploff, own});
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    r = $urandom(39);
    repeat (6) @(posedge clk);
    srst <= 0;
    rd(8'h04, 34'h0);
    rd(`ADDR_VSTATE, {18'h0, `VSTATE_RST});
    rd(8'h60, {`RESP_DECERR, 32'h0});
    wr(8'h60, 16'h1, `RESP_DECERR);
    wr(8'h00, 16'h0033, `RESP_SLVERR);
    rd(`ADDR_STATUS, st(1, 0, 0, 0));
    wr(8'h00, `CODE_MAX, `RESP_OKAY);
    wr(8'h04, `CODE_MAX, `RESP_SLVERR);
    wr(8'h00, `CODE_MAX, `RESP_OKAY);
    run <= 1;
    wr(8'h08, 16'h5, `RESP_SLVERR);
    rd(`ADDR_STATUS, st(1, 1, 0, 0));
    run <= 0;
    wr(`ADDR_STATUS, 16'h1, `RESP_OKAY);
    for (i = 0; i < 4; i++) wr({i[5:0], 2'b00}, 16'(i + 1), `RESP_OKAY);
    $display("setup test done");
    for (k = 0; k < 16; k++) begin
      r = $urandom;
      close <= {r[9:0], k[3:0]};
      repeat (4) @(posedge clk);
      rd(`ADDR_STATUS, st(0, 0, 0, k[3:0]));
      rd(`ADDR_INSTAT, {20'h0, r[9:0], k[3:0]});
      chk({(k == 0), k[3:0], 1'b1, 3'h0, 1'b0, 1'b0, 14'h0});
    end
    $display("speed test done");
    for (k = 0; k < 4; k++) begin
      r = $urandom;
      vs = $urandom;
      card <= vs[21:16];
      close <= r[13:0];
      wr(`ADDR_VSTATE, vs[15:0], `RESP_OKAY);
      repeat (4) @(posedge clk);
      rd(`ADDR_INSTAT, {20'h0, (card & r[13:8]) | (~card & ~vs[13:8]), r[7:0]});
      rd(`ADDR_VSTATE, {18'h0, vs[15:0]});
    end
    card <= 6'h3f;
    close <= 14'h000b;
    $display("virtual test done");
    wr(`ADDR_PIDEN, 16'h1, `RESP_OKAY);
    rd(`ADDR_STATUS, st(0, 0, 0, 4'hb));
    chk({1'b0, 4'hb, 1'b1, 3'h0, 1'b0, 1'b0, 14'h0});
    wr(`ADDR_CTRL, 16'h1, `RESP_OKAY);
    rd(`ADDR_STATUS, st(0, 0, 0, 4'h8));
    chk({1'b0, 4'h8, 1'b0, 3'h3, 1'b1, 1'b0, 14'h0});
    close <= 14'h0;
    repeat (4) @(posedge clk);
    rd(`ADDR_STATUS, st(0, 0, 0, 0));
    chk({1'b1, 4'h0, 1'b1, 3'h0, 1'b1, 1'b0, 14'h0});
    wr(`ADDR_PIDEN, 16'h0, `RESP_OKAY);
    $display("pid test done");
    plc_on <= 1;
    claim <= 14'h000f;
    close <= 14'h000f;
    repeat (6) @(posedge clk);
    rd(`ADDR_STATUS, st(0, 0, 0, 0));
    chk({1'b1, 4'h0, 1'b1, 3'h0, 1'b0, 1'b0, 14'h000f});
    for (k = 36; k < 38; k++) begin
      wr(8'h10, 16'(k), `RESP_OKAY);
      close <= 14'h001f;
      repeat (6) @(posedge clk);
      rd(`ADDR_STATUS, st(0, 0, 1, 4'hf));
      chk({1'b0, 4'hf, 1'b1, 3'h0, 1'b0, 1'b1, 14'h0});
      close <= 14'h000f;
      repeat (6) @(posedge clk);
      rd(`ADDR_STATUS, st(0, 0, 0, 0));
      chk({1'b1, 4'h0, 1'b1, 3'h0, 1'b0, 1'b0, 14'h000f});
    end
    $display("plc test done");
    finish_test();
  end
endmodule
